// ===== rtl/stcr_top.sv
// Seek and tune control registers with an APB slave and the channel search engine.
//
// Behaviour
// - Bit 11 selects standard or verbose RDS.
// - Limit bit 0 wraps at band edges.
// - Limit bit 1 ends seek at edge.
// - Direction bit 9: 0 down, 1 up.
// - Seek bit 8 starts from current channel.
// - Seek ends: valid, band done, edge.
// - Seek end raises operation complete flag.
// - Seek without valid channel raises fail flag.
// - Clearing seek bit clears flags; gates restart.
// - Clearing seek bit mid-seek aborts it.
// - Tune bit 15 high starts a tune.
// - Tune end raises operation complete flag.
// - Clearing tune bit clears complete flag.
// - Channel number is bits 9:0.
// - Band 00: spacing times channel plus 87.5.
// - Band 01/10: spacing times channel plus 76.
// - Seek never rewrites host channel number.
// - Readback tracks tuned channel during seek.
// - Spacing comes from bits 5:4 elsewhere.
// - Complete flag reads at status bit 14.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module stcr_top
    import stcr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rf_settle_done,
    input wire logic rf_channel_valid,
    output logic [16:0] rf_freq_khz,
    output logic rf_tune_strobe,
    output logic rds_verbose,
    output logic power_up_req,
    output logic power_down_req
);

    // Whole state of the block, registered in one place.
    typedef struct packed {
        logic [15:0] power_cfg;      // Power and seek configuration word.
        logic [15:0] channel_number_ctl;       // Channel and tune request word.
        logic [15:0] band_cfg;       // Band and channel step word.
        logic op_done;               // Operation complete flag.
        logic seek_fail;             // Seek fail flag.
        logic [9:0] readback;        // Channel currently tuned.
        logic [9:0] start_channel_number;      // Channel the seek started from.
        stcr_state_e fsm;            // Engine state.
        logic [16:0] freq_khz;       // Frequency handed to the receiver.
        logic strobe;                // One-cycle retune request.
        logic [31:0] rdata;          // Read data captured in setup.
    } stcr_state_s;

    stcr_state_s st;        // Current state.
    stcr_state_s next_st;   // Next state.

    // Decoded controls.
    logic seek_req;
    logic tune_req;
    logic seek_up;
    logic stop_at_edge;
    logic [1:0] band_sel;
    logic [1:0] step_sel;
    logic [7:0] step_khz;
    logic [16:0] base_khz;
    logic [9:0] max_channel_number;
    logic [9:0] cand;
    logic at_edge;
    logic addr_hit;
    logic setup_ph;
    logic wr_en;

    // Frequency of a channel in the selected band and step.
    function automatic logic [16:0] stcr_freq(input logic [16:0] base, input logic [7:0] step,
                                              input logic [9:0] channel_number);
        logic [17:0] prod;
        prod = step * channel_number;
        return base + prod[16:0];
    endfunction : stcr_freq

    // Highest channel that still lies inside the band.
    function automatic logic [9:0] stcr_max(input logic [1:0] band, input logic [1:0] step);
        logic [16:0] span;
        logic [16:0] q;
        span = (band == 2'b00) ? (STCR_TOP_WIDE_KHZ - STCR_BASE_WIDE_KHZ) :
               (band == 2'b10) ? (STCR_TOP_NARROW_KHZ - STCR_BASE_LOW_KHZ) :
                                 (STCR_TOP_WIDE_KHZ - STCR_BASE_LOW_KHZ);
        // Division by a constant step; the band edges never change at run time.
        case (step)
            2'b00: q = span / 17'(STCR_STEP_200_KHZ);
            2'b01: q = span / 17'(STCR_STEP_100_KHZ);
            default: q = span / 17'(STCR_STEP_50_KHZ);
        endcase
        return q[9:0];
    endfunction : stcr_max

    // Control fields feeding the engine and the outputs.
    always_comb begin
        seek_req = st.power_cfg[STCR_POS_SEEK_REQ];
        tune_req = st.channel_number_ctl[STCR_POS_TUNE_REQ];
        seek_up = st.power_cfg[STCR_POS_SEEK_DIR];
        stop_at_edge = st.power_cfg[STCR_POS_SEEK_LIMIT];
        band_sel = st.band_cfg[STCR_POS_BAND +: 2];
        step_sel = st.band_cfg[STCR_POS_STEP +: 2];
        // Band 11 has no defined use and is treated like band 01.
        base_khz = (band_sel == 2'b00) ? STCR_BASE_WIDE_KHZ
                                       : STCR_BASE_LOW_KHZ;
        if (step_sel == 2'b00) begin
            step_khz = STCR_STEP_200_KHZ;
        end else if (step_sel == 2'b01) begin
            step_khz = STCR_STEP_100_KHZ;
        end else begin
            step_khz = STCR_STEP_50_KHZ;
        end
        max_channel_number = stcr_max(band_sel, step_sel);
        // One channel step in the chosen direction, wrapping at the edges.
        at_edge = seek_up ? (st.readback >= max_channel_number) : (st.readback == 10'h000);
        if (seek_up) begin
            cand = at_edge ? 10'h000 : st.readback + 10'h001;
        end else begin
            cand = at_edge ? max_channel_number : st.readback - 10'h001;
        end
    end

    // APB decode; the slave never inserts wait states.
    always_comb begin
        setup_ph = psel && !penable;
        wr_en = psel && penable && pwrite;
        addr_hit = (paddr == STCR_ADDR_POWER) || (paddr == STCR_ADDR_CHANNEL_NUMBER) ||
                   (paddr == STCR_ADDR_BAND) || (paddr == STCR_ADDR_STATUS);
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit;
    assign prdata = st.rdata;
    assign rf_freq_khz = st.freq_khz;
    assign rf_tune_strobe = st.strobe;
    assign rds_verbose = st.power_cfg[STCR_POS_RDS_DETAIL];
    assign power_up_req = st.power_cfg[STCR_POS_POWER_UP];
    assign power_down_req = st.power_cfg[STCR_POS_POWER_DOWN];

    // Next state: register writes, read capture and the tune and seek engine.
    always_comb begin
        next_st = st;
        next_st.strobe = 1'b0;
        // Read data is captured in the setup cycle so that it comes from a flop.
        if (setup_ph) begin
            if (paddr == STCR_ADDR_POWER) begin
                next_st.rdata = {16'h0000, st.power_cfg};
            end else if (paddr == STCR_ADDR_CHANNEL_NUMBER) begin
                next_st.rdata = {16'h0000, st.channel_number_ctl};
            end else if (paddr == STCR_ADDR_BAND) begin
                next_st.rdata = {16'h0000, st.band_cfg};
            end else if (paddr == STCR_ADDR_STATUS) begin
                // Status word: completion at bit 14, fail at 13, readback low.
                next_st.rdata = 32'h0000_0000;
                next_st.rdata[STCR_POS_DONE] = st.op_done;
                next_st.rdata[STCR_POS_FAIL] = st.seek_fail;
                next_st.rdata[9:0] = st.readback;
            end else begin
                next_st.rdata = 32'h0000_0000;
            end
        end
        // Writes land in the access cycle; the status word ignores them.
        // Reserved bits are stored as written, software keeps them at zero.
        if (wr_en) begin
            if (paddr == STCR_ADDR_POWER) begin
                next_st.power_cfg = pwdata[15:0];
            end else if (paddr == STCR_ADDR_CHANNEL_NUMBER) begin
                next_st.channel_number_ctl = pwdata[15:0];
            end else if (paddr == STCR_ADDR_BAND) begin
                next_st.band_cfg = pwdata[15:0];
            end
        end
        // The engine only reads channel_number_ctl, it never writes it back.
        unique case (st.fsm)
            STCR_IDLE: begin
                // A new operation needs the flags cleared, which DONE guarantees.
                if (tune_req) begin
                    next_st.readback = st.channel_number_ctl[STCR_CHANNEL_NUMBER_W-1:0];
                    next_st.freq_khz = stcr_freq(base_khz, step_khz,
                                                 st.channel_number_ctl[STCR_CHANNEL_NUMBER_W-1:0]);
                    next_st.strobe = 1'b1;
                    next_st.fsm = STCR_TUNE_WAIT;
                end else if (seek_req) begin
                    next_st.start_channel_number = st.readback;
                    next_st.fsm = STCR_SEEK_STEP;
                end
            end
            STCR_TUNE_WAIT: begin
                // A tune dropped by software before settling ends without a flag.
                if (!tune_req) begin
                    next_st.fsm = STCR_IDLE;
                end else if (rf_settle_done) begin
                    next_st.op_done = 1'b1;
                    next_st.fsm = STCR_DONE;
                end
            end
            STCR_SEEK_STEP: begin
                if (!seek_req) begin
                    next_st.fsm = STCR_IDLE;
                end else if ((at_edge && stop_at_edge) || (cand == st.start_channel_number)) begin
                    // Edge in stop mode or a full lap in wrap mode.
                    next_st.op_done = 1'b1;
                    next_st.seek_fail = 1'b1;
                    next_st.fsm = STCR_DONE;
                end else begin
                    // Move one channel, wrapping in wrap mode.
                    next_st.readback = cand;
                    next_st.freq_khz = stcr_freq(base_khz, step_khz, cand);
                    next_st.strobe = 1'b1;
                    next_st.fsm = STCR_SEEK_WAIT;
                end
            end
            STCR_SEEK_WAIT: begin
                if (!seek_req) begin
                    next_st.fsm = STCR_IDLE;
                end else if (rf_settle_done && rf_channel_valid) begin
                    next_st.op_done = 1'b1;
                    next_st.fsm = STCR_DONE;
                end else if (rf_settle_done) begin
                    next_st.fsm = STCR_SEEK_STEP;
                end
            end
            STCR_DONE: begin
                // Flags fall only once both request bits are low.
                if (!seek_req && !tune_req) begin
                    next_st.op_done = 1'b0;
                    next_st.seek_fail = 1'b0;
                    next_st.fsm = STCR_IDLE;
                end
            end
            default: begin
                next_st.fsm = STCR_IDLE;
            end
        endcase
    end

    // State register with synchronous reset.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st.power_cfg <= STCR_POWER_RST;
            st.channel_number_ctl <= STCR_CHANNEL_NUMBER_RST;
            st.band_cfg <= STCR_BAND_RST;
            st.op_done <= 1'b0;
            st.seek_fail <= 1'b0;
            st.readback <= 10'h000;
            st.start_channel_number <= 10'h000;
            st.fsm <= STCR_IDLE;
            st.freq_khz <= STCR_BASE_WIDE_KHZ;
            st.strobe <= 1'b0;
            st.rdata <= 32'h0000_0000;
        end else begin
            st <= next_st;
        end
    end

    // Checks on the engine, all in the core clock domain.
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // A retune request: one strobe cycle while the engine waits, never a second one.
    // Checking the wait state in the strobe cycle keeps a legal abort from tripping it.
    sequence seq_retune;
        st.strobe && (st.fsm == STCR_SEEK_WAIT) ##1 !st.strobe;
    endsequence
    sequence seq_tune_go;
        (st.fsm == STCR_IDLE) && tune_req && !wr_en;
    endsequence

    rds_mode_a: assert property (
        rds_verbose == st.power_cfg[STCR_POS_RDS_DETAIL])
        else $error("RDS detail output does not follow its bit.");

    // Wrapping upward from the top channel restarts at channel zero.
    wrap_edge_a: assert property (
        (st.fsm == STCR_SEEK_STEP) && seek_req && !stop_at_edge && seek_up && at_edge &&
        (st.start_channel_number != 10'h000) |=> (st.readback == 10'h000) && st.strobe)
        else $error("Seek up did not wrap to channel zero.");

    // In stop mode the edge channel ends the seek with the fail flag.
    stop_edge_a: assert property (
        (st.fsm == STCR_SEEK_STEP) && seek_req && stop_at_edge && at_edge
        |=> st.op_done && st.seek_fail && (st.readback == $past(st.readback)))
        else $error("Seek did not stop at the band edge.");

    step_dir_a: assert property (
        (st.fsm == STCR_SEEK_STEP) && seek_req && !at_edge && (cand != st.start_channel_number)
        |=> (st.readback == ($past(seek_up) ? $past(st.readback) + 10'h001
                                      : $past(st.readback) - 10'h001)) ##0 seq_retune)
        else $error("Seek stepped the wrong way or by more than one channel.");

    seek_start_a: assert property (
        (st.fsm == STCR_IDLE) && seek_req && !tune_req
        |=> (st.fsm == STCR_SEEK_STEP) && (st.start_channel_number == $past(st.readback)))
        else $error("Seek did not start from the tuned channel.");

    seek_found_a: assert property (
        (st.fsm == STCR_SEEK_WAIT) && seek_req && rf_settle_done && rf_channel_valid
        |=> st.op_done && !st.seek_fail && (st.fsm == STCR_DONE))
        else $error("Qualified channel did not complete the seek.");

    clear_flags_a: assert property (
        (st.fsm == STCR_DONE) && !seek_req && !tune_req
        |=> !st.op_done && !st.seek_fail ##1 (st.fsm != STCR_DONE))
        else $error("Clearing the request did not clear the flags.");

    abort_a: assert property (
        ((st.fsm == STCR_SEEK_STEP) || (st.fsm == STCR_SEEK_WAIT)) && !seek_req
        |=> (st.fsm == STCR_IDLE) && !st.op_done)
        else $error("Seek was not aborted.");

    tune_freq_a: assert property (
        seq_tune_go |=> st.strobe && (st.readback == $past(st.channel_number_ctl[9:0])) &&
        (st.freq_khz == stcr_freq($past(base_khz), $past(step_khz),
                                  $past(st.channel_number_ctl[9:0]))))
        else $error("Tune frequency does not match channel mapping.");

    tune_done_a: assert property (
        (st.fsm == STCR_TUNE_WAIT) && tune_req && rf_settle_done
        |=> st.op_done ##1 (st.op_done || !$past(tune_req)))
        else $error("Tune end did not raise the complete flag.");

    channel_number_hold_a: assert property (
        (st.fsm != STCR_IDLE) && !wr_en |=> $stable(st.channel_number_ctl))
        else $error("Channel number changed without a host write.");

    no_restart_a: assert property (
        st.op_done |=> (st.fsm == STCR_DONE) || !st.op_done)
        else $error("New operation began with the complete flag set.");

    // A host write lands in the access cycle and nowhere else.
    channel_number_write_a: assert property (
        wr_en && (paddr == STCR_ADDR_CHANNEL_NUMBER) |=> (st.channel_number_ctl == $past(pwdata[15:0])))
        else $error("Channel register did not take the written word.");

    // Wrapping downward from channel zero continues at the top of the band.
    wrap_low_a: assert property (
        (st.fsm == STCR_SEEK_STEP) && seek_req && !stop_at_edge && !seek_up && at_edge &&
        (st.start_channel_number != max_channel_number) |=> (st.readback == $past(max_channel_number)) && st.strobe)
        else $error("Seek down did not wrap to the top channel.");

    // The status word shows the flags and the tuned channel as they stood in setup.
    status_read_a: assert property (
        setup_ph && (paddr == STCR_ADDR_STATUS)
        |=> (prdata[STCR_POS_DONE] == $past(st.op_done)) &&
            (prdata[STCR_POS_FAIL] == $past(st.seek_fail)) &&
            (prdata[9:0] == $past(st.readback)))
        else $error("Status word does not show the flags and tuned channel.");

    // A settled but unqualified candidate sends the engine on to the next one.
    seek_next_a: assert property (
        (st.fsm == STCR_SEEK_WAIT) && seek_req && rf_settle_done && !rf_channel_valid
        |=> (st.fsm == STCR_SEEK_STEP) && !st.op_done)
        else $error("Unqualified candidate did not move the seek on.");

    // A full lap in wrap mode gives up with both flags set.
    lap_fail_a: assert property (
        (st.fsm == STCR_SEEK_STEP) && seek_req && !(at_edge && stop_at_edge) &&
        (cand == st.start_channel_number) |=> st.op_done && st.seek_fail && (st.fsm == STCR_DONE))
        else $error("Seek lap did not end with the fail flag.");

endmodule : stcr_top

// ===== pkg/stcr_pkg.sv
// Package with register map, field positions, band tables and states of the seek and tune block.
package stcr_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] STCR_IDX_POWER = 8'h02;
    localparam logic [7:0] STCR_IDX_CHANNEL_NUMBER = 8'h03;
    localparam logic [7:0] STCR_IDX_BAND = 8'h05;
    localparam logic [7:0] STCR_IDX_STATUS = 8'h0a;
    localparam logic [7:0] STCR_ADDR_POWER = STCR_IDX_POWER << 2;
    localparam logic [7:0] STCR_ADDR_CHANNEL_NUMBER = STCR_IDX_CHANNEL_NUMBER << 2;
    localparam logic [7:0] STCR_ADDR_BAND = STCR_IDX_BAND << 2;
    localparam logic [7:0] STCR_ADDR_STATUS = STCR_IDX_STATUS << 2;

    // Reset values of the writable registers.
    localparam logic [15:0] STCR_POWER_RST = 16'h0000;
    localparam logic [15:0] STCR_CHANNEL_NUMBER_RST = 16'h0000;
    localparam logic [15:0] STCR_BAND_RST = 16'h0000;

    // Field positions in the power and seek configuration register.
    localparam int STCR_POS_RDS_DETAIL = 11;
    localparam int STCR_POS_SEEK_LIMIT = 10;
    localparam int STCR_POS_SEEK_DIR = 9;
    localparam int STCR_POS_SEEK_REQ = 8;
    localparam int STCR_POS_POWER_DOWN = 6;
    localparam int STCR_POS_POWER_UP = 0;
    // Field positions in the channel, band and status registers.
    localparam int STCR_POS_TUNE_REQ = 15;
    localparam int STCR_CHANNEL_NUMBER_W = 10;
    localparam int STCR_POS_BAND = 6;
    localparam int STCR_POS_STEP = 4;
    localparam int STCR_POS_DONE = 14;
    localparam int STCR_POS_FAIL = 13;

    // Band edges and channel steps in kHz; frequencies fit in 17 bits.
    localparam logic [16:0] STCR_BASE_WIDE_KHZ = 17'h155cc;  // 87500 kHz.
    localparam logic [16:0] STCR_BASE_LOW_KHZ = 17'h128e0;   // 76000 kHz.
    localparam logic [16:0] STCR_TOP_WIDE_KHZ = 17'h1a5e0;   // 108000 kHz.
    localparam logic [16:0] STCR_TOP_NARROW_KHZ = 17'h15f90; // 90000 kHz.
    localparam logic [7:0] STCR_STEP_200_KHZ = 8'hc8;
    localparam logic [7:0] STCR_STEP_100_KHZ = 8'h64;
    localparam logic [7:0] STCR_STEP_50_KHZ = 8'h32;

    // States of the tune and seek engine.
    typedef enum logic [2:0] {
        STCR_IDLE = 3'b000,
        STCR_TUNE_WAIT = 3'b001,
        STCR_SEEK_STEP = 3'b010,
        STCR_SEEK_WAIT = 3'b011,
        STCR_DONE = 3'b100
    } stcr_state_e;

endpackage : stcr_pkg

// ===== test/stcr_rf_model.sv
// Behavioural receiver that settles after each retune and reports one good frequency.
`timescale 1ns/1ps
module stcr_rf_model
    import stcr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [16:0] rf_freq_khz,
    input wire logic rf_tune_strobe,
    input wire logic [16:0] good_khz,
    input wire logic slow,
    output logic rf_settle_done,
    output logic rf_channel_valid
);
    logic [3:0] wait_cnt; // Cycles left until the receiver reports settled.
    logic toggle; // Filler level for the valid line outside a report.

    // Settle only after a retune, never on its own, so the engine has to wait for it.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wait_cnt <= 4'h0;
            toggle <= 1'b0;
        end else begin
            toggle <= ~toggle;
            if (rf_tune_strobe) begin
                wait_cnt <= slow ? 4'h9 : 4'h2;
            end else if (wait_cnt != 4'h0) begin
                wait_cnt <= wait_cnt - 4'h1;
            end
        end
    end

    // Valid means something only beside the settle pulse, so elsewhere it toggles.
    assign rf_settle_done = (wait_cnt == 4'h1);
    assign rf_channel_valid = rf_settle_done ? (rf_freq_khz == good_khz) : toggle;
endmodule : stcr_rf_model

// ===== test/stcr_tb_top.sv
// Self-checking bench for the seek and tune registers with a behavioural receiver.
`timescale 1ns/1ps
module stcr_tb_top
    import stcr_pkg::*;
;
    logic core_clk = 1'b0; // Clock at 250 MHz.
    logic rst_n = 1'b0; // Synchronous reset, active low.
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rf_settle_done;
    logic rf_channel_valid;
    logic [16:0] rf_freq_khz;
    logic rf_tune_strobe;
    logic rds_verbose;
    logic power_up_req;
    logic power_down_req;
    logic [16:0] good_khz = 17'h0; // Only frequency the receiver accepts.
    logic slow = 1'b0; // Makes the receiver settle late.
    int num_errors = 0;
    int cmp_count = 0;
    int n_strobe = 0; // Retunes seen since last cleared.
    logic [31:0] d;
    logic err;
    logic [9:0] ch;
    logic [16:0] e;
    logic [15:0] band_tab [3] = '{16'h0050, 16'h00a0, 16'h0000};
    logic [16:0] base_tab [3] = '{STCR_BASE_LOW_KHZ, STCR_BASE_LOW_KHZ, STCR_BASE_WIDE_KHZ};
    logic [7:0] step_tab [3] = '{STCR_STEP_100_KHZ, STCR_STEP_50_KHZ, STCR_STEP_200_KHZ};

    // Free-running clock, 4 ns period.
    always #2 core_clk = ~core_clk;

    // Counted on the falling edge so the flop has settled.
    always @(negedge core_clk) begin
        if (rf_tune_strobe === 1'b1) begin
            n_strobe++;
        end
    end

    stcr_top dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rf_settle_done(rf_settle_done), .rf_channel_valid(rf_channel_valid),
        .rf_freq_khz(rf_freq_khz), .rf_tune_strobe(rf_tune_strobe), .rds_verbose(rds_verbose),
        .power_up_req(power_up_req), .power_down_req(power_down_req));

    stcr_rf_model rf (.core_clk(core_clk), .rst_n(rst_n), .rf_freq_khz(rf_freq_khz),
        .rf_tune_strobe(rf_tune_strobe), .good_khz(good_khz), .slow(slow),
        .rf_settle_done(rf_settle_done), .rf_channel_valid(rf_channel_valid));

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    // Compares one value with its expectation; unknowns never match.
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    // One APB transfer; waits for pready under a bound, then idles one cycle.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] wd,
                       output logic [31:0] rdat, output logic e_out);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'h0, wd};
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            num_errors++;
            close_out();
        end
        rdat = prdata;
        e_out = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [15:0] wd);
        logic [31:0] x;
        logic y;
        apb(1'b1, a, wd, x, y);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] rdat);
        logic y;
        apb(1'b0, a, 16'h0, rdat, y);
    endtask : rd

    // Polls status until the completion flag rises, under a bound.
    task automatic wait_done();
        logic [31:0] s;
        int n;
        s = 32'h0;
        n = 0;
        while (s[STCR_POS_DONE] !== 1'b1 && n < 1000) begin
            rd(STCR_ADDR_STATUS, s);
            n++;
        end
        if (s[STCR_POS_DONE] !== 1'b1) begin
            num_errors++;
            close_out();
        end
    endtask : wait_done

    // Main sequence: reset, registers, tunes in every band, seeks, abort.
    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rd(STCR_ADDR_POWER, d);
        chk_val(d, 32'h0);
        rd(STCR_ADDR_CHANNEL_NUMBER, d);
        chk_val(d, 32'h0);
        chk_val({15'h0, rf_freq_khz}, {15'h0, STCR_BASE_WIDE_KHZ});
        wr(STCR_ADDR_POWER, 16'h0841);
        rd(STCR_ADDR_POWER, d);
        chk_val(d, 32'h0841);
        chk_val({29'h0, rds_verbose, power_up_req, power_down_req}, 32'h7);
        wr(STCR_ADDR_POWER, 16'h0000);
        chk_val({29'h0, rds_verbose, power_up_req, power_down_req}, 32'h0);
        wr(STCR_ADDR_STATUS, 16'hffff);
        rd(STCR_ADDR_STATUS, d);
        chk_val(d, 32'h0);
        apb(1'b0, 8'h40, 16'h0, d, err);
        chk_val({d[30:0], err}, 32'h1);
        // Tunes in each band and step; the band 00 entry comes last.
        for (int i = 0; i < 3; i++) begin
            ch = 10'(i + 3);
            e = base_tab[i] + 17'(step_tab[i]) * 17'(ch);
            wr(STCR_ADDR_BAND, band_tab[i]);
            wr(STCR_ADDR_CHANNEL_NUMBER, {6'h20, ch});
            wait_done();
            chk_val({15'h0, rf_freq_khz}, {15'h0, e});
            rd(STCR_ADDR_STATUS, d);
            chk_val(d, 32'h4000 | {22'h0, ch});
            wr(STCR_ADDR_CHANNEL_NUMBER, {6'h0, ch});
            rd(STCR_ADDR_STATUS, d);
            chk_val(d, {22'h0, ch});
        end
        // Seek up from channel 5 finds channel 8.
        good_khz <= STCR_BASE_WIDE_KHZ + 17'(STCR_STEP_200_KHZ) * 17'd8;
        wr(STCR_ADDR_POWER, 16'h0300);
        wait_done();
        rd(STCR_ADDR_STATUS, d);
        chk_val(d, 32'h4008);
        chk_val({15'h0, rf_freq_khz}, {15'h0, good_khz});
        rd(STCR_ADDR_CHANNEL_NUMBER, d);
        chk_val(d, 32'h5);
        wr(STCR_ADDR_POWER, 16'h0200);
        rd(STCR_ADDR_STATUS, d);
        chk_val(d, 32'h8);
        // Seek down in stop mode with nothing to find ends at the lower edge.
        good_khz <= 17'h0;
        wr(STCR_ADDR_POWER, 16'h0500);
        wait_done();
        rd(STCR_ADDR_STATUS, d);
        chk_val(d, 32'h6000);
        wr(STCR_ADDR_POWER, 16'h0400);
        // Seek down in wrap mode laps the whole band: 102 candidates.
        n_strobe = 0;
        wr(STCR_ADDR_POWER, 16'h0100);
        wait_done();
        rd(STCR_ADDR_STATUS, d);
        chk_val(d & 32'h6000, 32'h6000);
        chk_val(32'(n_strobe), 32'd102);
        wr(STCR_ADDR_POWER, 16'h0000);
        // A slow seek dropped midway stops retuning and raises no flag.
        slow <= 1'b1;
        wr(STCR_ADDR_POWER, 16'h0100);
        repeat (6) @(posedge core_clk);
        wr(STCR_ADDR_POWER, 16'h0000);
        repeat (20) @(posedge core_clk);
        n_strobe = 0;
        repeat (40) @(posedge core_clk);
        chk_val(32'(n_strobe), 32'd0);
        rd(STCR_ADDR_STATUS, d);
        chk_val(d & 32'h6000, 32'h0);
        close_out();
    end
endmodule : stcr_tb_top
